// file: cssseq_top.sv
// clock source select, domain gating and start-up sequencing with axi slave
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module cssseq_top
  import cssseq_pkg::*;
#(
  parameter logic [15:0] TOUT_LONG_CYC   = cssseq_pkg::TOUT_LONG,
  parameter logic [15:0] SETTLE_LP_CYC   = cssseq_pkg::SETTLE_LP_LONG,
  parameter logic [15:0] SETTLE_LF_CYC   = cssseq_pkg::SETTLE_LF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        other_reset_active,
  input  wire logic        wdt_osc_tick,
  input  wire logic        lp_xtal_tick,
  input  wire logic        lf_xtal_tick,
  input  wire logic        rc_osc_tick,
  input  wire logic        ext_clk_tick,
  input  wire logic        async_src_tick,
  input  wire logic        pll_out_tick,
  input  wire logic        ext_int_level,
  input  wire logic        two_wire_addr_match,
  input  wire logic        wake_event,
  output logic             int_reset_n,
  output logic             core_clock,
  output logic             peripheral_clock,
  output logic             program_memory_clock,
  output logic             async_timer_clock,
  output logic             converter_clock,
  output logic             serial_bus_48m_clock,
  output logic [3:0]       pll_prescale
);
  import cssseq_pkg::*;

  cssseq_state_type state_ff, nxt_state;
  logic [11:0] ctrl_ff;
  logic [3:0]  clock_source_select_fuses;
  logic [1:0]  startup_time_fuses;
  logic        divide_by_eight_fuse;
  logic [3:0]  act_src_ff;
  logic [1:0]  act_start_ff;
  logic        act_div_ff;
  logic [3:0]  plldiv_ff;
  logic [15:0] cnt_ff;
  logic [2:0]  div_ff;
  logic        exti_ff;
  logic [5:0]  gate_ff;
  logic        bvalid_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff, bresp_ff;

  // source decode from the latched fuse image; reserved codes fall back to rc
  wire src_lp   = act_src_ff[3];
  wire src_lf   = act_src_ff[3:1] == 3'h2;
  wire src_rc   = act_src_ff == 4'h2;
  wire src_ext  = act_src_ff == 4'h0;
  wire src_rsv  = !(src_lp || src_lf || src_rc || src_ext);
  cssseq_src_type src_sel;
  assign src_sel = src_lp ? SRC_LP_XTAL : src_lf ? SRC_LF_XTAL :
                   src_ext ? SRC_EXT : SRC_RC;

  // selected oscillator and divide-by-eight (zero means programmed)
  wire osc_tick = src_lp ? lp_xtal_tick : src_lf ? lf_xtal_tick :
                  src_ext ? ext_clk_tick : rc_osc_tick;
  wire div_on    = !act_div_ff;
  wire root_tick = osc_tick && (!div_on || div_ff == DIV8_LAST);

  // time-out length in watchdog cycles; start-up code 00: brown-out guards
  wire [15:0] tout_len = (act_start_ff == 2'h0) ? 16'h0000 :
                         (act_start_ff == 2'h1) ? TOUT_SHORT :
                         TOUT_LONG_CYC;

  // settling length in oscillator cycles per clock type
  wire [15:0] lp_len =
    (!act_src_ff[0] && !act_start_ff[1]) ? SETTLE_LP_FAST :
    (!act_src_ff[0] || act_start_ff == 2'h0) ? SETTLE_LP_MID : SETTLE_LP_CYC;
  wire [15:0] settle_len = src_lp ? lp_len :
                           src_lf ? SETTLE_LF_CYC : SETTLE_EXT;

  // sleep request decode
  cssseq_sleep_type slp_mode;
  assign slp_mode = cssseq_sleep_type'(ctrl_ff[CTRL_MODE_LSB +: 2]);
  wire deep_sleep = slp_mode == SLP_POWER_DOWN ||
                    slp_mode == SLP_POWER_SAVE;
  // interrupt and address match wake in every mode, no gated clock needed
  wire wake_any = wake_event || ext_int_level || two_wire_addr_match;
  wire sleep_go = ctrl_ff[CTRL_SLEEP_BIT];
  wire tout_done   = cnt_ff >= tout_len;
  wire settle_done = cnt_ff >= settle_len;

  // sequencer: hold, time-out on watchdog, settling on oscillator, run
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HOLD: begin
        if (!other_reset_active) begin
          nxt_state = ST_TIMEOUT;
        end
      end
      ST_TIMEOUT: begin
        if (tout_done) begin
          nxt_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_go) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          nxt_state = deep_sleep ? ST_SETTLE : ST_RUN;
        end
      end
      default: nxt_state = ST_HOLD;
    endcase
    if (other_reset_active) begin
      nxt_state = ST_HOLD;
    end
  end

  // the counter restarts on every state change; the tick source is picked
  // by state so one counter serves both phases
  wire cnt_tick = (state_ff == ST_TIMEOUT) ? wdt_osc_tick : osc_tick;
  wire [15:0] nxt_cnt = (nxt_state != state_ff) ? 16'h0000 :
                        (cnt_tick && cnt_ff != 16'hffff) ? cnt_ff + 16'h1 :
                        cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_HOLD;
      cnt_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // fuse image is caught when the hold phase ends, so a rewrite takes
  // effect at the next reset sequence, not mid-run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_src_ff   <= FUSE_SRC_RESET;
      act_start_ff <= FUSE_START_RESET;
      act_div_ff   <= FUSE_DIV_RESET;
    end else if (state_ff == ST_HOLD) begin
      act_src_ff   <= clock_source_select_fuses;
      act_start_ff <= startup_time_fuses;
      act_div_ff   <= divide_by_eight_fuse;
    end
  end

  // divide-by-eight prescaler on the selected oscillator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 3'h0;
    end else if (osc_tick) begin
      div_ff <= div_on ? div_ff + 3'h1 : 3'h0;
    end
  end

  // domain gate targets: core, periph, flash, async, adc, usb
  wire running = state_ff == ST_RUN;
  wire asleep  = state_ff == ST_SLEEP;
  wire want_core   = running;
  wire want_periph = ctrl_ff[CTRL_PERIPH_BIT] &&
                     (running || (asleep && slp_mode == SLP_IDLE));
  wire want_flash  = want_core;
  wire want_async  = ctrl_ff[CTRL_ASYNC_BIT] && int_reset_n &&
                     !(asleep && slp_mode == SLP_POWER_DOWN);
  wire want_adc    = ctrl_ff[CTRL_ADC_BIT] && int_reset_n &&
                     !(asleep && deep_sleep);
  wire want_usb    = ctrl_ff[CTRL_USB_BIT] && running;
  wire [5:0] nxt_gate = {want_usb, want_adc, want_async,
                         want_flash, want_periph, want_core};

  // gates move only between root pulses so no core, periph, flash or adc pulse is ever cut short;
  // the oscillator ticks must therefore leave gaps between pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_ff <= 6'h00;
    end else if (!root_tick) begin
      gate_ff <= nxt_gate;
    end
  end

  // domain clocks as enable pulses; async and usb run from their own sources
  assign core_clock           = root_tick && gate_ff[0];
  assign peripheral_clock     = root_tick && gate_ff[1];
  assign program_memory_clock = root_tick && gate_ff[2];
  assign async_timer_clock    = async_src_tick && want_async;
  assign converter_clock      = root_tick && gate_ff[4];
  assign serial_bus_48m_clock = pll_out_tick && want_usb;
  assign int_reset_n          = running || asleep;
  assign pll_prescale         = plldiv_ff;

  // axi write: address and data are taken together, one at a time
  wire wr_go   = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  wire wr_ctrl = wr_go && s_axi_awaddr == CSSSEQ_CTRL_OFS && s_axi_wstrb[0];
  wire wr_ctl1 = wr_go && s_axi_awaddr == CSSSEQ_CTRL_OFS && s_axi_wstrb[1];
  wire wr_fuse = wr_go && s_axi_awaddr == CSSSEQ_FUSE_OFS && s_axi_wstrb[0];
  wire wr_stat = wr_go && s_axi_awaddr == CSSSEQ_STATUS_OFS &&
                 s_axi_wstrb[0];
  wire wr_pll  = wr_go && s_axi_awaddr == CSSSEQ_PLLDIV_OFS && s_axi_wstrb[0];
  wire wr_map = s_axi_awaddr <= CSSSEQ_PLLDIV_OFS && s_axi_awaddr[1:0] == 2'h0;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // sleep request self-clears whenever the sequencer is out of run, in sleep and during the reset sequence
  wire sleep_clr = state_ff == ST_SLEEP || state_ff != ST_RUN;
  wire [11:0] nxt_ctrl = {wr_ctl1 ? s_axi_wdata[11:8] : ctrl_ff[11:8],
                          wr_ctrl ? s_axi_wdata[7:1] : ctrl_ff[7:1],
                          wr_ctrl ? s_axi_wdata[0] :
                          (sleep_clr ? 1'b0 : ctrl_ff[0])};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff   <= CTRL_RESET;
      plldiv_ff <= PLLDIV_RESET;
      clock_source_select_fuses <= FUSE_SRC_RESET;
      startup_time_fuses        <= FUSE_START_RESET;
      divide_by_eight_fuse      <= FUSE_DIV_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_pll) begin
        plldiv_ff <= s_axi_wdata[3:0];
      end
      if (wr_fuse) begin
        clock_source_select_fuses <= s_axi_wdata[FUSE_SRC_LSB +: 4];
        startup_time_fuses        <= s_axi_wdata[FUSE_START_LSB +: 2];
        divide_by_eight_fuse      <= s_axi_wdata[FUSE_DIV_BIT];
      end
    end
  end

  // sticky external interrupt seen; sampled on the free clock, so a halted
  // peripheral domain cannot miss it; a new event beats a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exti_ff <= 1'b0;
    end else if (ext_int_level) begin
      exti_ff <= 1'b1;
    end else if (wr_stat && s_axi_wdata[STAT_EXTI_BIT]) begin
      exti_ff <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_map ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read decode; unmapped addresses answer slverr with zero data
  wire rd_go = s_axi_arvalid && !rvalid_ff;
  wire [31:0] stat_word = {24'h0, exti_ff, src_rsv, src_sel,
                           int_reset_n, 3'(state_ff)};
  wire [31:0] rd_word =
    (s_axi_araddr == CSSSEQ_CTRL_OFS)   ? {20'h0, ctrl_ff} :
    (s_axi_araddr == CSSSEQ_FUSE_OFS)   ? {25'h0, divide_by_eight_fuse,
                                           startup_time_fuses,
                                           clock_source_select_fuses} :
    (s_axi_araddr == CSSSEQ_STATUS_OFS) ? stat_word :
    (s_axi_araddr == CSSSEQ_PLLDIV_OFS) ? {28'h0, plldiv_ff} : 32'h0;
  wire rd_map = s_axi_araddr <= CSSSEQ_PLLDIV_OFS && s_axi_araddr[1:0] == 2'h0;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= 2'h0;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // checks on the sequencer, gates, source decode and time-out length
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_held: assert property ((state_ff == ST_TIMEOUT ||
    state_ff == ST_SETTLE || state_ff == ST_HOLD) |-> !int_reset_n)
    else $error("internal reset released early");
  a_hold_exit: assert property ((state_ff == ST_HOLD && !other_reset_active)
    |=> state_ff == ST_TIMEOUT)
    else $error("hold did not move to time-out");
  a_tout_then_settle: assert property ((state_ff == ST_TIMEOUT &&
    tout_done && !other_reset_active) |=> state_ff == ST_SETTLE)
    else $error("settling did not follow time-out");
  a_settle_release: assert property ((state_ff == ST_SETTLE && settle_done
    && !other_reset_active) |=> int_reset_n)
    else $error("reset not released after settling");
  a_wake_skip: assert property ((state_ff == ST_SLEEP && wake_any &&
    deep_sleep && !other_reset_active) |=> state_ff == ST_SETTLE)
    else $error("deep wake did not skip time-out");
  a_gate_low: assert property ($changed(gate_ff) |-> !$past(root_tick))
    else $error("gate switched during a clock pulse");
  a_flash_core: assert property (program_memory_clock == core_clock)
    else $error("program memory clock split from core clock");
  a_async_sleep: assert property ((asleep && slp_mode == SLP_POWER_SAVE &&
    ctrl_ff[CTRL_ASYNC_BIT] && async_src_tick) |-> async_timer_clock)
    else $error("async timer stopped in power-save");
  a_src_ext: assert property ((act_src_ff == 4'h0) |-> src_sel == SRC_EXT)
    else $error("external clock code misdecoded");
  a_tout_len: assert property ((act_start_ff == 2'h1) |->
    tout_len == TOUT_SHORT) else $error("short time-out length wrong");
  c_boot: cover property (state_ff == ST_SETTLE ##1 state_ff == ST_RUN);
  c_deep_wake: cover property (state_ff == ST_SLEEP && deep_sleep
    ##1 state_ff == ST_SETTLE);
  c_idle_wake: cover property (state_ff == ST_SLEEP && !deep_sleep
    ##1 state_ff == ST_RUN);
endmodule // cssseq_top

// file: cssseq_pkg.sv
// constants and types shared by the clock select and start-up sequencer
package cssseq_pkg;
  // register byte offsets
  localparam logic [7:0] CSSSEQ_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CSSSEQ_FUSE_OFS   = 8'h04;
  localparam logic [7:0] CSSSEQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] CSSSEQ_PLLDIV_OFS = 8'h0c;
  // control register fields
  localparam int CTRL_SLEEP_BIT  = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int CTRL_ASYNC_BIT  = 8;
  localparam int CTRL_ADC_BIT    = 9;
  localparam int CTRL_USB_BIT    = 10;
  localparam int CTRL_PERIPH_BIT = 11;
  localparam logic [11:0] CTRL_RESET = 12'hf00;
  // fuse register fields; a fuse bit of one is unprogrammed
  localparam int FUSE_SRC_LSB   = 0;
  localparam int FUSE_START_LSB = 4;
  localparam int FUSE_DIV_BIT   = 6;
  localparam logic [3:0] FUSE_SRC_RESET   = 4'he;
  localparam logic [1:0] FUSE_START_RESET = 2'h1;
  localparam logic       FUSE_DIV_RESET   = 1'b0;
  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RUN_BIT   = 3;
  localparam int STAT_SRC_LSB   = 4;
  localparam int STAT_RSV_BIT   = 6;
  localparam int STAT_EXTI_BIT  = 7;
  localparam logic [3:0] PLLDIV_RESET = 4'h0;
  // start-up counts: time-outs in watchdog cycles, settling in oscillator cycles
  localparam logic [15:0] TOUT_SHORT     = 16'd512;
  localparam logic [15:0] TOUT_LONG      = 16'd8192;
  localparam logic [15:0] SETTLE_EXT     = 16'd6;
  localparam logic [15:0] SETTLE_LP_FAST = 16'd258;
  localparam logic [15:0] SETTLE_LP_MID  = 16'd1024;
  localparam logic [15:0] SETTLE_LP_LONG = 16'd16384;
  localparam logic [15:0] SETTLE_LF      = 16'd32768;
  localparam logic [2:0]  DIV8_LAST      = 3'h7;
  typedef enum logic [1:0] {
    SRC_LP_XTAL, SRC_LF_XTAL, SRC_RC, SRC_EXT
  } cssseq_src_type;
  typedef enum logic [1:0] {
    SLP_IDLE, SLP_ADC_QUIET, SLP_POWER_DOWN, SLP_POWER_SAVE
  } cssseq_sleep_type;
  typedef enum logic [2:0] {
    ST_HOLD, ST_TIMEOUT, ST_SETTLE, ST_RUN, ST_SLEEP
  } cssseq_state_type;
endpackage

// file: cssseq_osc_model.sv
// pulse model of the oscillators and clock sources around the sequencer
`timescale 1ns/10ps
module cssseq_osc_model #(
  parameter int P_WDT = 2,
  parameter int P_LP  = 3,
  parameter int P_LF  = 4,
  parameter int P_RC  = 2,
  parameter int P_EXT = 5,
  parameter int P_ASY = 7,
  parameter int P_PLL = 2
) (
  input  wire logic aclk,
  output logic      wdt_osc_tick,
  output logic      lp_xtal_tick,
  output logic      lf_xtal_tick,
  output logic      rc_osc_tick,
  output logic      ext_clk_tick,
  output logic      async_src_tick,
  output logic      pll_out_tick
);
  logic [31:0] cyc_ff = 32'h0;
  // free-running sources; periods of two or more leave the idle cycles
  // that the domain gates need, 32 bits so no wrap spoils a period
  always_ff @(posedge aclk) cyc_ff <= cyc_ff + 32'h1;
  assign wdt_osc_tick   = (cyc_ff % P_WDT) == 0;
  assign lp_xtal_tick   = (cyc_ff % P_LP) == 0;
  assign lf_xtal_tick   = (cyc_ff % P_LF) == 0;
  assign rc_osc_tick    = (cyc_ff % P_RC) == 0;
  assign ext_clk_tick   = (cyc_ff % P_EXT) == 0;
  assign async_src_tick = (cyc_ff % P_ASY) == 0;
  assign pll_out_tick   = (cyc_ff % P_PLL) == 0;
endmodule // cssseq_osc_model

// file: test_clock_select_startup_sequencer.sv
// self-checking bench for the clock select and start-up sequencer
`timescale 1ns/10ps
module test_clock_select_startup_sequencer;
  import cssseq_pkg::*;
  localparam int LIMIT = 40000;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irst_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic other_rst, ext_int, two_wire, wake, wdt, lp, lf, rc, ext, asy, pll;
  logic [3:0] wstrb, strb_sel;
  logic core, per, flash, asyc, adc, usb;
  logic [3:0] psc;
  logic [5:0] clk_vec;
  int cnt [6];
  int n_mismatch, tests_run, cyc;
  assign clk_vec = {usb, asyc, adc, per, flash, core};

  cssseq_top #(.TOUT_LONG_CYC(16'd20), .SETTLE_LP_CYC(16'd30),
    .SETTLE_LF_CYC(16'd40)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .other_reset_active(other_rst), .wdt_osc_tick(wdt),
    .lp_xtal_tick(lp), .lf_xtal_tick(lf), .rc_osc_tick(rc),
    .ext_clk_tick(ext), .async_src_tick(asy), .pll_out_tick(pll),
    .ext_int_level(ext_int), .two_wire_addr_match(two_wire),
    .wake_event(wake),
    .int_reset_n(irst_n), .core_clock(core), .peripheral_clock(per),
    .program_memory_clock(flash), .async_timer_clock(asyc),
    .converter_clock(adc), .serial_bus_48m_clock(usb), .pll_prescale(psc));

  cssseq_osc_model u_osc (.aclk(aclk), .wdt_osc_tick(wdt),
    .lp_xtal_tick(lp), .lf_xtal_tick(lf), .rc_osc_tick(rc),
    .ext_clk_tick(ext), .async_src_tick(asy), .pll_out_tick(pll));

  // clock at 25 MHz
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // hang guard: counts as a mismatch and closes the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  task automatic near(input string w, input int e, g, s);
    tests_run++;
    if (g < e - s || g > e + s) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d seen %0d", w, e, g);
    end
  endtask

  // handshakes are judged at the falling edge, so the taking rising edge
  // is known before it arrives and release happens right after it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // n counts cycles until the selected signal goes high
  task automatic wait_hi(input bit use_core, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((use_core ? core : irst_n) !== 1'b1);
  endtask

  task automatic count(input int n);
    // two edges first so a gate change queued behind a pulse has landed;
    // an unknown pulse counts huge so no zero or near check can pass it
    cnt = '{default: 0};
    repeat (2) @(posedge aclk);
    repeat (n) begin
      @(negedge aclk);
      foreach (cnt[i])
        cnt[i] += (clk_vec[i] === 1'b0) ? 0 : (clk_vec[i] === 1'b1) ? 1 : 9999;
    end
  endtask

  // new fuses take effect only through a fresh hold of the other resets
  task automatic boot(input logic [7:0] f, input int e);
    int n;
    axi_wr(CSSSEQ_FUSE_OFS, {24'h0, f});
    @(posedge aclk);
    other_rst <= 1'b1;
    repeat (2) @(posedge aclk);
    other_rst <= 1'b0;
    wait_hi(1'b0, n);
    near("release cycles", e, n, 12);
  endtask

  task automatic t_regs();
    axi_rd(CSSSEQ_FUSE_OFS);
    chk("fuse reset", 32'h1e, rd);
    axi_rd(CSSSEQ_CTRL_OFS);
    chk("ctrl reset", 32'hf00, rd);
    axi_rd(8'h10);
    chk("unmapped read data", 32'h0, rd);
    chk("unmapped read resp", 2'h2, resp);
    axi_wr(8'h14, 32'h1);
    chk("unmapped write", 2'h2, resp);
    axi_wr(CSSSEQ_PLLDIV_OFS, 32'h5);
    chk("prescaler", 4'h5, psc);
    strb_sel = 4'h1;
    axi_wr(CSSSEQ_CTRL_OFS, 32'h4);
    strb_sel = 4'hf;
    axi_rd(CSSSEQ_CTRL_OFS);
    chk("ctrl lane zero only", 32'hf04, rd);
    $display("test registers done");
  endtask

  task automatic t_fuse();
    logic [7:0] f_tab [7] = '{8'h00, 8'h12, 8'h24, 8'h05, 8'h0f, 8'h38,
      8'h31};
    int e_tab [7] = '{30, 1036, 200, 160, 3072, 3112, 52};
    foreach (f_tab[i]) boot(f_tab[i], e_tab[i]);
    axi_rd(CSSSEQ_STATUS_OFS);
    chk("reserved to rc", 3'h6, {rd[6], rd[5:4]});
    $display("test fuse table done");
  endtask

  task automatic t_div();
    boot(8'h4e, 774);
    count(240);
    near("core undivided", 80, cnt[0], 2);
    chk("flash with core", cnt[0], cnt[1]);
    chk("usb running", 1, cnt[5] > 0);
    boot(8'h0e, 774);
    count(240);
    near("core divided", 10, cnt[0], 1);
    $display("test divider done");
  endtask

  task automatic t_sleep();
    int n;
    boot(8'h50, 1054);
    axi_wr(CSSSEQ_CTRL_OFS, 32'hf01);
    count(40);
    chk("idle core flash", 0, cnt[0] + cnt[1]);
    chk("idle adc periph", 2'h3, {cnt[3] > 0, cnt[2] > 0});
    @(posedge aclk);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    axi_wr(CSSSEQ_CTRL_OFS, 32'hf05);
    count(40);
    chk("down clocks", 0, cnt[0] + cnt[2] + cnt[3] + cnt[4]);
    @(posedge aclk);
    ext_int <= 1'b1;
    wait_hi(1'b1, n);
    @(posedge aclk);
    ext_int <= 1'b0;
    near("wake settle only", 33, n, 15);
    axi_rd(CSSSEQ_STATUS_OFS);
    chk("ext flag", 1'b1, rd[7]);
    axi_wr(CSSSEQ_STATUS_OFS, 32'h80);
    axi_rd(CSSSEQ_STATUS_OFS);
    chk("ext flag clear", 1'b0, rd[7]);
    axi_wr(CSSSEQ_CTRL_OFS, 32'hf07);
    count(40);
    chk("save async only", 2'h1, {cnt[0] > 0, cnt[4] > 0});
    @(posedge aclk);
    two_wire <= 1'b1;
    wait_hi(1'b1, n);
    @(posedge aclk);
    two_wire <= 1'b0;
    near("two wire wake", 33, n, 15);
    $display("test sleep done");
  endtask

  // main sequence
  initial begin
    int n;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {other_rst, ext_int, two_wire, wake} = 4'h0;
    wstrb = 4'hf;
    strb_sel = 4'hf;
    {awaddr, araddr, wdata} = 48'h0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wait_hi(1'b0, n);
    near("first release", 1798, n, 12);
    t_regs();
    t_fuse();
    t_div();
    t_sleep();
    give_verdict();
  end
endmodule // test_clock_select_startup_sequencer
